// ---- anvrc_host.sv ----
// host controller driving the asynchronous 16-bit non-volatile memory pins
`timescale 1ns/10ps
module anvrc_host
    import anvrc_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYC
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // user request
    input  wire logic              reqValid,
    input  wire logic              reqWrite,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic [DATA_W-1:0] reqData,
    input  wire logic [LANES-1:0]  reqLanes,
    output logic                   reqReady,
    // user response
    output logic                   rspValid,
    output logic [DATA_W-1:0]      rspData,
    // memory pins
    output logic [ADDR_W-1:0]      memAddr,
    output logic                   chipSelectN,
    output logic                   writeStrobeN,
    output logic                   outputDriveN,
    output logic                   lowLaneSelectN,
    output logic                   highLaneSelectN,
    // shared data pins
    input  wire logic [DATA_W-1:0] dqIn,
    output logic [DATA_W-1:0]      dqOut,
    output logic                   dqOe
);

    // access plus rest must span the select cycle time
    if (STARTUP_CYCLES < 1 || READ_CYC >= 2**CNT_W || WRITE_CYC >= 2**CNT_W || RECOVER_CYC >= 2**CNT_W
        || READ_CYC + HIGH_CYC + 1 < CYCLE_CYC || WRITE_CYC + RECOVER_CYC + 1 < CYCLE_CYC) begin : g_check
        $error("anvrc_host: timing counts out of range");
    end

    localparam logic [CNT_W-1:0] READ_LAST    = CNT_W'(READ_CYC - 1);
    localparam logic [CNT_W-1:0] WRITE_LAST   = CNT_W'(WRITE_CYC - 1);
    localparam logic [CNT_W-1:0] RECOVER_LAST = CNT_W'(RECOVER_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_LAST     = CNT_W'(HIGH_CYC - 1);
    localparam logic [31:0]      POWER_LAST   = 32'(STARTUP_CYCLES - 1);

    anvrc_state_t     state_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [31:0]      powerCnt_reg;
    logic [LANES-1:0] lanes_next;
    logic             accept;

    assign accept = (state_reg == ST_IDLE) && reqReady && reqValid;
    // an empty lane mask would frame a write that stores nothing
    assign lanes_next = (reqLanes == '0) ? LANES_ALL : reqLanes;

    // startup wait
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            powerCnt_reg <= '0;
        end else if (state_reg == ST_POWER) begin
            powerCnt_reg <= powerCnt_reg + 32'h1;
        end
    end

    // sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_POWER;
            cnt_reg   <= '0;
        end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
            case (state_reg)
                ST_POWER: begin
                    // hold off for the startup time
                    if (powerCnt_reg == POWER_LAST) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    cnt_reg <= '0;
                    if (accept) begin
                        state_reg <= reqWrite ? ST_WRITE : ST_READ;
                    end
                end
                ST_READ: begin
                    if (cnt_reg == READ_LAST) begin
                        state_reg <= ST_GAP;
                        cnt_reg   <= '0;
                    end
                end
                ST_WRITE: begin
                    if (cnt_reg == WRITE_LAST) begin
                        state_reg <= ST_RECOVER;
                        cnt_reg   <= '0;
                    end
                end
                ST_RECOVER: begin
                    if (cnt_reg == RECOVER_LAST) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_GAP: begin
                    // select held high before the next access
                    if (cnt_reg == GAP_LAST) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ready only after the startup wait or the rest, spacing select falls
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reqReady <= 1'b0;
        end else if (accept) begin
            reqReady <= 1'b0;
        end else if ((state_reg == ST_POWER && powerCnt_reg == POWER_LAST)
                  || (state_reg == ST_RECOVER && cnt_reg == RECOVER_LAST)
                  || (state_reg == ST_GAP && cnt_reg == GAP_LAST)) begin
            reqReady <= 1'b1;
        end
    end

    // read data capture
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rspValid <= 1'b0;
            rspData  <= '0;
        end else begin
            rspValid <= 1'b0;
            if (state_reg == ST_READ && cnt_reg == READ_LAST) begin
                rspValid <= 1'b1;
                rspData  <= dqIn;
            end
        end
    end

    // address pins change only on a new access
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            memAddr <= '0;
        end else if (accept) begin
            // address moves with the select edge, zero setup
            memAddr <= reqAddr;
        end
    end

    // control strobes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chipSelectN     <= 1'b1;
            writeStrobeN    <= 1'b1;
            outputDriveN    <= 1'b1;
            lowLaneSelectN  <= 1'b1;
            highLaneSelectN <= 1'b1;
        end else if (accept) begin
            // select and lanes fall together, with the strobe too on a write
            chipSelectN     <= 1'b0;
            writeStrobeN    <= ~reqWrite;
            // output drive only for reads, strobe stays high
            outputDriveN    <= reqWrite;
            // lanes frame the same pulse as select, one cycle on a write, two on a read
            // lane mask onto the two lane selects
            lowLaneSelectN  <= ~lanes_next[0];
            highLaneSelectN <= ~lanes_next[1];
        end else if ((state_reg == ST_READ && cnt_reg == READ_LAST)
                  || (state_reg == ST_WRITE && cnt_reg == WRITE_LAST)) begin
            // select and strobe end the write together
            chipSelectN     <= 1'b1;
            writeStrobeN    <= 1'b1;
            outputDriveN    <= 1'b1;
            lowLaneSelectN  <= 1'b1;
            highLaneSelectN <= 1'b1;
        end
    end

    // data pin drive
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dqOut <= '0;
            dqOe  <= 1'b0;
        end else if (accept && reqWrite) begin
            // data valid a full pulse before the write ends
            dqOut <= reqData;
            dqOe  <= 1'b1;
        end else if (state_reg == ST_WRITE && cnt_reg == WRITE_LAST) begin
            // release with the strobe rise, zero hold suffices
            dqOe  <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence readStart;
        $fell(chipSelectN) && writeStrobeN;
    endsequence

    sequence writeStart;
        $fell(writeStrobeN);
    endsequence

    read_strobe_high_a: assert property (readStart |-> writeStrobeN [*2] ##1 chipSelectN)
        else $error("strobe not high through read");
    read_data_time_a: assert property (readStart |-> ##2 rspValid)
        else $error("read data not captured after access time");
    store_overlap_a: assert property (!writeStrobeN |-> !chipSelectN && dqOe
                                      && !(lowLaneSelectN && highLaneSelectN))
        else $error("write strobe outside select and lane overlap");
    strobe_rest_a: assert property (!writeStrobeN |=> writeStrobeN && chipSelectN)
        else $error("no high interval after write");
    select_spacing_a: assert property ($fell(chipSelectN) |=> (!$fell(chipSelectN)) [*2])
        else $error("chip select falls too close");
    write_recovery_a: assert property (writeStart |=> memAddr == $past(memAddr) ##1 !dqOe)
        else $error("address moved before recovery");
    write_addr_setup_a: assert property (writeStart |-> $fell(chipSelectN) && outputDriveN)
        else $error("write not framed by select edge");
    write_pulse_a: assert property (writeStart |-> !writeStrobeN [*1] ##1 writeStrobeN)
        else $error("write pulse length wrong");
    write_data_a: assert property (writeStart |-> dqOe && (dqOut == $past(reqData)))
        else $error("write data not valid at strobe");
    select_end_a: assert property ($rose(writeStrobeN) |-> $rose(chipSelectN))
        else $error("select and strobe do not end together");
    startup_hold_a: assert property (state_reg == ST_POWER |-> chipSelectN && writeStrobeN && !reqReady)
        else $error("access during startup");
    drive_write_a: assert property (dqOe |-> outputDriveN && !writeStrobeN)
        else $error("data driven outside write");

endmodule

// ---- anvrc_host_tb.sv ----
// self-checking bench for the host controller against the memory model
`timescale 1ns/10ps
module anvrc_host_tb;
    import anvrc_pkg::*;
    localparam int STUP = 4;
    logic              clk = 1'h0;
    logic              reset = 1'h1;
    logic              reqValid = 1'h0;
    logic              reqWrite = 1'h0;
    logic [ADDR_W-1:0] reqAddr = 18'h00000;
    logic [DATA_W-1:0] reqData = 16'h0000;
    logic [LANES-1:0]  reqLanes = 2'h3;
    logic              slow = 1'h0;
    logic              reqReady, rspValid, chipSelectN, writeStrobeN, outputDriveN;
    logic              lowLaneSelectN, highLaneSelectN, dqOe;
    logic [DATA_W-1:0] rspData, dqOut, dq;
    logic [ADDR_W-1:0] memAddr, wsAddr;
    int                failures = 0;
    int                samplesChecked = 0;
    int                cycles = 0;
    realtime           csFall = -100.0;
    realtime           wsFall = 0.0;

    always #10 clk = ~clk;

    anvrc_host #(.STARTUP_CYCLES(STUP)) anvrc_host_inst (.clk, .reset, .reqValid, .reqWrite, .reqAddr,
        .reqData, .reqLanes, .reqReady, .rspValid, .rspData, .memAddr, .chipSelectN, .writeStrobeN,
        .outputDriveN, .lowLaneSelectN, .highLaneSelectN, .dqIn(dq), .dqOut, .dqOe);
    anvrc_mem_model anvrc_mem_model_inst (.memAddr, .chipSelectN, .writeStrobeN, .outputDriveN,
        .lowLaneSelectN, .highLaneSelectN, .dqOut, .dqOe, .slow, .dq);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            print_verdict();
        end
    end

    always @(negedge chipSelectN) begin
        check($realtime - csFall >= 35.0, 1'h1);
        csFall = $realtime;
    end
    always @(negedge outputDriveN) check({writeStrobeN, dqOe}, 2'h2);
    always @(negedge writeStrobeN) begin
        wsFall = $realtime;
        #1 wsAddr = memAddr;
    end
    // the reset in t_reset lands on the strobe rise and clears the address
    always @(posedge writeStrobeN) if (!reset) begin
        check($realtime - wsFall >= 15.0, 1'h1);
        check(memAddr, wsAddr);
    end

    task automatic req(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [LANES-1:0] l);
        int n;
        n = 0;
        @(posedge clk);
        reqValid <= 1'h1;
        reqWrite <= w;
        reqAddr <= a;
        reqData <= d;
        reqLanes <= l;
        @(posedge clk);
        while (reqReady !== 1'h1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        reqValid <= 1'h0;
        check(n < 20, 1'h1);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] l, input logic [DATA_W-1:0] e,
                      input logic [DATA_W-1:0] m);
        req(1'h0, a, 16'h0000, l);
        repeat (2) @(posedge clk);
        #1;
        check(rspValid, 1'h1);
        check(rspData & m, e & m);
    endtask

    task automatic t_power();
        int n;
        n = 0;
        @(posedge clk);
        reset <= 1'h1;
        repeat (8) @(posedge clk);
        check({reqReady, dqOe, chipSelectN, writeStrobeN, outputDriveN}, 5'h07);
        reset <= 1'h0;
        while (reqReady !== 1'h1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
            check({chipSelectN, writeStrobeN}, 2'h3);
        end
        check(n, STUP);
    endtask

    task automatic t_word();
        req(1'h1, 18'h00001, 16'h1234, 2'h3);
        req(1'h1, 18'h3FFFF, 16'hF00D, 2'h3);
        rd(18'h00001, 2'h3, 16'h1234, 16'hFFFF);
        rd(18'h3FFFF, 2'h3, 16'hF00D, 16'hFFFF);
    endtask

    task automatic t_lanes();
        req(1'h1, 18'h00002, 16'hAAAA, 2'h3);
        req(1'h1, 18'h00002, 16'h55CC, 2'h1);
        req(1'h1, 18'h00002, 16'h7711, 2'h2);
        req(1'h1, 18'h00003, 16'hBEEF, 2'h0);
        rd(18'h00002, 2'h3, 16'h77CC, 16'hFFFF);
        rd(18'h00002, 2'h1, 16'h00CC, 16'h00FF);
        rd(18'h00002, 2'h2, 16'h7700, 16'hFF00);
        rd(18'h00003, 2'h0, 16'hBEEF, 16'hFFFF);
    endtask

    task automatic t_slow();
        @(posedge clk);
        slow <= 1'h1;
        rd(18'h00002, 2'h3, 16'h77CC, 16'hFFFF);
        slow <= 1'h0;
    endtask

    // alternating writes and reads at the tightest spacing
    task automatic t_b2b();
        for (int i = 0; i < 4; i++) begin
            req(1'h1, 18'h00004 + 18'(i), 16'hA500 | 16'(i), 2'h3);
            rd(18'h00004 + 18'(i), 2'h3, 16'hA500 | 16'(i), 16'hFFFF);
        end
    endtask

    task automatic t_reset();
        req(1'h1, 18'h00005, 16'h0BAD, 2'h3);
        t_power();
        rd(18'h00001, 2'h3, 16'h1234, 16'hFFFF);
    endtask

    initial begin
        t_power();
        t_word();
        t_lanes();
        t_slow();
        t_b2b();
        t_reset();
        print_verdict();
    end
endmodule

// ---- anvrc_mem_model.sv ----
// behavioural model of the 16-bit non-volatile memory seen from its pins
`timescale 1ns/10ps
module anvrc_mem_model
    import anvrc_pkg::*;
(
    // memory pins
    input  wire logic [ADDR_W-1:0] memAddr,
    input  wire logic              chipSelectN,
    input  wire logic              writeStrobeN,
    input  wire logic              outputDriveN,
    input  wire logic              lowLaneSelectN,
    input  wire logic              highLaneSelectN,
    // host side of the data pins and access speed
    input  wire logic [DATA_W-1:0] dqOut,
    input  wire logic              dqOe,
    input  wire logic              slow,
    output logic [DATA_W-1:0]      dq
);
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] rdWord;
    logic [1:0]        laneOn;
    logic [1:0]        laneDrv;
    logic [23:0]       wBus;
    initial foreach (mem[i]) mem[i] = 16'h0000;
    // store at overlap end; delayed copy keeps pre-edge values
    assign #1 wBus = {chipSelectN, writeStrobeN, memAddr[3:0], highLaneSelectN, lowLaneSelectN, dq};
    always @(posedge chipSelectN or posedge writeStrobeN) begin
        if (wBus[23:22] == 2'h0) begin
            if (!wBus[16]) mem[wBus[21:18]][7:0] = wBus[7:0];
            if (!wBus[17]) mem[wBus[21:18]][15:8] = wBus[15:8];
        end
    end
    // lanes drive only on a clean read
    assign laneOn = {~highLaneSelectN, ~lowLaneSelectN} & {2{~chipSelectN & ~outputDriveN & writeStrobeN}};
    // on after 5 ns, or after access time when slow, off at once
    always @(laneOn) begin
        if (laneOn == 2'h0) laneDrv = 2'h0;
        else laneDrv <= #(slow ? T_ACCESS_NS : 5) laneOn;
    end
    // old word held 3 ns after address moves
    assign #3 rdWord = mem[memAddr[3:0]];
    // released lanes show the inverse, so a stale sample never matches
    assign dq[7:0]  = dqOe ? dqOut[7:0] : laneDrv[0] ? rdWord[7:0] : ~rdWord[7:0];
    assign dq[15:8] = dqOe ? dqOut[15:8] : laneDrv[1] ? rdWord[15:8] : ~rdWord[15:8];
endmodule

// ---- anvrc_pkg.sv ----
// constants for the host controller of the asynchronous 16-bit non-volatile memory
package anvrc_pkg;

    localparam int ADDR_W       = 18;
    localparam int DATA_W       = 16;
    localparam int LANES        = 2;
    localparam int CLK_PERIOD_PS = 20000;

    // pin timing in ns as the memory demands
    localparam int T_CYCLE_NS     = 35;
    localparam int T_ACCESS_NS    = 35;
    localparam int T_WR_PULSE_NS  = 15;
    localparam int T_ADDR_END_NS  = 18;
    localparam int T_DATA_END_NS  = 10;
    localparam int T_RECOVERY_NS  = 12;
    localparam int T_HIGH_NS      = 2;
    localparam longint T_STARTUP_NS = 2000000;

    // least times round up, never below one cycle
    function automatic int min_cycles(input longint ns);
        longint c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : int'(c);
    endfunction

    localparam int READ_CYC   = min_cycles(T_ACCESS_NS);
    localparam int WRITE_CYC  = (min_cycles(T_WR_PULSE_NS) > min_cycles(T_ADDR_END_NS)) ?
                                min_cycles(T_WR_PULSE_NS) : min_cycles(T_ADDR_END_NS);
    localparam int RECOVER_CYC = min_cycles(T_RECOVERY_NS);
    localparam int HIGH_CYC    = min_cycles(T_HIGH_NS);
    localparam int CYCLE_CYC   = min_cycles(T_CYCLE_NS);
    localparam int STARTUP_CYC = min_cycles(T_STARTUP_NS);
    localparam int CNT_W       = 4;

    localparam logic [LANES-1:0] LANES_ALL = 2'h3;

    typedef enum logic [2:0] {
        ST_POWER,
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_RECOVER,
        ST_GAP
    } anvrc_state_t;

endpackage
